// ===== rtl/init_reset_ctrl.sv
// initial reset sequencer with watchdog, reset causes and load control register
// assumes an AXI4-Lite master on aclk; pins are asynchronous to aclk
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module init_reset_ctrl
  import reset_pkg::*;
#(
  parameter int       PIN_HOLD        = PIN_HOLD_CYCLES,
  parameter int       KEY_HOLD        = KEY_HOLD_CYCLES,
  parameter key_sel_t KEY_COMBO       = KEY_0123,
  parameter bit       PIN_ACTIVE_HIGH = 1'b1
) (
  input  wire logic              aclk,             // 25 MHz clock
  input  wire logic              aresetn,          // sync reset, low
  input  wire logic [ADDR_W-1:0] awaddr,           // write address
  input  wire logic [2:0]        awprot,           // unused
  input  wire logic              awvalid,          // write address valid
  output logic                   awready,          // write address ready
  input  wire logic [31:0]       wdata,            // write data
  input  wire logic [3:0]        wstrb,            // write strobes
  input  wire logic              wvalid,           // write data valid
  output logic                   wready,           // write data ready
  output logic [1:0]             bresp,            // write response
  output logic                   bvalid,           // write response valid
  input  wire logic              bready,           // write response ready
  input  wire logic [ADDR_W-1:0] araddr,           // read address
  input  wire logic [2:0]        arprot,           // unused
  input  wire logic              arvalid,          // read address valid
  output logic                   arready,          // read address ready
  output logic [31:0]            rdata,            // read data
  output logic [1:0]             rresp,            // read response
  output logic                   rvalid,           // read data valid
  input  wire logic              rready,           // read data ready
  input  wire logic              slow_osc,         // low-speed clock pin
  input  wire logic              slow_osc_running, // oscillator started
  input  wire logic              ext_reset_pin,    // external reset pin
  input  wire logic [3:0]        key_inputs,       // key pins
  input  wire logic              wdt_tick,         // 1 Hz pulse, aclk domain
  output logic                   init_reset,       // initial reset, high
  output logic [7:0]             pc_step,          // step start value
  output logic [3:0]             pc_page,          // page start value
  output logic                   pc_bank,          // bank start value
  output logic [3:0]             next_page_ptr,    // new page start value
  output logic                   next_bank_ptr,    // new bank start value
  output logic                   int_flag,         // interrupt flag value
  output logic                   dec_flag,         // decimal flag value
  output logic                   heavy_load_sel,   // heavy-load mode
  output logic                   all_dots_blank,   // all dots off
  output logic                   all_dots_lit,     // all dots on
  output logic                   drive_duty_sel    // drive duty select
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic [6:0]        sync1;
    logic [6:0]        sync2;
    logic              slow_prev;
    logic              por_pending;
    seq_state_t        state;
    logic              init_reset;
    logic [1:0]        wdt_cnt;
    logic [4:0]        cause;
    logic [3:0]        load_ctrl;
    logic [7:0]        pc_step;
    logic [3:0]        pc_page;
    logic              pc_bank;
    logic [3:0]        next_page;
    logic              next_bank;
    logic              int_flag;
    logic              dec_flag;
    logic              aw_held;
    logic [ADDR_W-1:0] awaddr_q;
    logic              w_held;
    logic [31:0]       wdata_q;
    logic              wstrb_q;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } state_t;

  state_t r;
  state_t n;

  ////////////////////////////////////////////////////////////////////////////
  // synchronised pins and sources

  logic       slow_s;
  logic       osc_run_s;
  logic       pin_s;
  logic [3:0] keys_s;
  logic       slow_edge;
  logic       pin_level;
  logic [3:0] key_mask;
  logic       keys_low;
  logic       pin_hit;
  logic       key_hit;
  logic       wdt_fire;
  logic       src;

  assign slow_s    = r.sync2[0];
  assign osc_run_s = r.sync2[1];
  assign pin_s     = r.sync2[2];
  assign keys_s    = r.sync2[6:3];
  assign slow_edge = slow_s && !r.slow_prev;
  assign pin_level = PIN_ACTIVE_HIGH ? pin_s : !pin_s;

  always_comb begin
    unique case (KEY_COMBO)
      KEY_OFF:  key_mask = 4'h0;
      KEY_01:   key_mask = 4'h3;
      KEY_012:  key_mask = 4'h7;
      KEY_0123: key_mask = 4'hf;
    endcase
  end

  assign keys_low = (key_mask != 4'h0) && ((keys_s & key_mask) == 4'h0);

  hold_qualifier #(
    .CYCLES (PIN_HOLD)
  ) u_pin_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (pin_level),
    .hit     (pin_hit)
  );

  hold_qualifier #(
    .CYCLES (KEY_HOLD)
  ) u_key_filter (
    .aclk    (aclk),
    .aresetn (aresetn),
    .level   (keys_low),
    .hit     (key_hit)
  );

  assign wdt_fire = wdt_tick && (r.wdt_cnt == WDT_LAST_TICK) && (r.state == ST_RUN);
  assign src      = r.por_pending | pin_hit | key_hit | wdt_fire;

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  logic wr_go;
  logic wr_hit;
  logic wr_restart;
  logic ar_go;
  logic ar_hit;

  assign wr_go  = r.aw_held && r.w_held && !r.bvalid;
  assign wr_hit = (r.awaddr_q == ADDR_LOAD_CTRL) || (r.awaddr_q == ADDR_WDT_CTRL) ||
                  (r.awaddr_q == ADDR_CAUSE);
  assign wr_restart = wr_go && r.wstrb_q && (r.awaddr_q == ADDR_WDT_CTRL) &&
                      r.wdata_q[WDT_RESTART_BIT];
  assign ar_go  = r.arready && arvalid;
  assign ar_hit = (araddr == ADDR_LOAD_CTRL) || (araddr == ADDR_WDT_CTRL) ||
                  (araddr == ADDR_CAUSE);

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = r;
    n.sync1     = {key_inputs, ext_reset_pin, slow_osc_running, slow_osc};
    n.sync2     = r.sync1;
    n.slow_prev = slow_s;

    if (osc_run_s) begin
      n.por_pending = 1'b0;
    end

    // watchdog: restarted by software or held cleared while in reset
    if ((r.state != ST_RUN) || wr_restart) begin
      n.wdt_cnt = 2'h0;
    end else if (wdt_tick) begin
      n.wdt_cnt = r.wdt_cnt + 2'h1;
    end

    unique case (r.state)
      ST_RUN: begin
        if (src) begin
          n.state      = ST_HOLD;
          n.init_reset = 1'b1;
        end
      end
      ST_HOLD: begin
        if (!src) begin
          n.state = ST_RELEASE;
        end
      end
      ST_RELEASE: begin
        if (src) begin
          n.state = ST_HOLD;
        end else if (slow_edge) begin
          n.state      = ST_RUN;
          n.init_reset = 1'b0;
        end
      end
      default: begin
        n.state      = ST_HOLD;
        n.init_reset = 1'b1;
      end
    endcase

    // write channel
    if (r.awready && awvalid) begin
      n.aw_held  = 1'b1;
      n.awaddr_q = awaddr;
    end
    if (r.wready && wvalid) begin
      n.w_held  = 1'b1;
      n.wdata_q = wdata;
      n.wstrb_q = wstrb[0];
    end
    if (r.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (wr_go) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (r.wstrb_q && (r.awaddr_q == ADDR_LOAD_CTRL)) begin
        n.load_ctrl = r.wdata_q[3:0];
      end
      if (r.wstrb_q && (r.awaddr_q == ADDR_CAUSE)) begin
        n.cause = r.cause & ~r.wdata_q[4:0];
      end
    end
    n.awready = !n.aw_held && !n.bvalid;
    n.wready  = !n.w_held && !n.bvalid;

    // cause flags: a new event wins over a clear in the same cycle
    n.cause[CAUSE_POR]    = n.cause[CAUSE_POR] | r.por_pending;
    n.cause[CAUSE_PIN]    = n.cause[CAUSE_PIN] | pin_hit;
    n.cause[CAUSE_KEY]    = n.cause[CAUSE_KEY] | key_hit;
    n.cause[CAUSE_WDT]    = n.cause[CAUSE_WDT] | wdt_fire;
    n.cause[CAUSE_ACTIVE] = r.init_reset;

    // read channel
    if (r.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (ar_go) begin
      n.rvalid = 1'b1;
      n.rresp  = ar_hit ? RESP_OKAY : RESP_SLVERR;
      if (araddr == ADDR_LOAD_CTRL) begin
        n.rdata = {28'h0, r.load_ctrl};
      end else if (araddr == ADDR_CAUSE) begin
        n.rdata = {27'h0, r.cause};
      end else begin
        n.rdata = 32'h0;
      end
    end
    n.arready = !n.rvalid;

    // initial reset: start values, control register back to defaults
    if (r.init_reset) begin
      n.load_ctrl = LOAD_CTRL_RESET;
      n.pc_step   = PC_STEP_INIT;
      n.pc_page   = PC_PAGE_INIT;
      n.pc_bank   = BANK_INIT;
      n.next_page = NEXT_PAGE_INIT;
      n.next_bank = BANK_INIT;
      n.int_flag  = FLAG_INIT;
      n.dec_flag  = FLAG_INIT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r             <= '0;
      r.por_pending <= 1'b1;
      r.state       <= ST_HOLD;
      r.init_reset  <= 1'b1;
      r.load_ctrl   <= LOAD_CTRL_RESET;
      r.pc_page     <= PC_PAGE_INIT;
      r.next_page   <= NEXT_PAGE_INIT;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign awready        = r.awready;
  assign wready         = r.wready;
  assign bvalid         = r.bvalid;
  assign bresp          = r.bresp;
  assign arready        = r.arready;
  assign rvalid         = r.rvalid;
  assign rdata          = r.rdata;
  assign rresp          = r.rresp;
  assign init_reset     = r.init_reset;
  assign pc_step        = r.pc_step;
  assign pc_page        = r.pc_page;
  assign pc_bank        = r.pc_bank;
  assign next_page_ptr  = r.next_page;
  assign next_bank_ptr  = r.next_bank;
  assign int_flag       = r.int_flag;
  assign dec_flag       = r.dec_flag;
  assign heavy_load_sel = r.load_ctrl[LC_HEAVY_BIT];
  assign all_dots_blank = r.load_ctrl[LC_BLANK_BIT];
  assign all_dots_lit   = r.load_ctrl[LC_LIT_BIT];
  assign drive_duty_sel = r.load_ctrl[LC_DUTY_BIT];

endmodule // init_reset_ctrl

// ===== shared/reset_pkg.sv
// constants, types and register map of the initial reset and load mode block
// assumes a 25 MHz aclk and a word-wide AXI4-Lite slave
//
// How it works
// - four sources combine into one initial reset
// - power-on holds reset until oscillator runs
// - reset pin filtered, held 2 ms
// - key combination low 2 s fires reset
// - build option picks key combination
// - watchdog timeout issues initial reset
// - reset loads step 00, page 1, banks 0
// - reset clears interrupt and decimal flags
// - heavy-load bit written and read back
// - initial reset clears heavy-load bit
// - watchdog fires after 3-4 unserviced seconds
package reset_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_HZ          = 25_000_000;
  localparam int PIN_HOLD_US     = 2000;
  localparam int PIN_HOLD_CYCLES = (CLK_HZ / 1000 * PIN_HOLD_US + 999) / 1000;
  localparam int KEY_HOLD_S      = 2;
  localparam int KEY_HOLD_CYCLES = CLK_HZ * KEY_HOLD_S;
  localparam logic [1:0] WDT_LAST_TICK = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // register map: printed offsets are word indices
  localparam int ADDR_W = 16;
  localparam logic [11:0] IDX_LOAD_CTRL = 12'hf71;
  localparam logic [11:0] IDX_WDT_CTRL  = 12'hf76;
  localparam logic [11:0] IDX_CAUSE     = 12'hf80;
  localparam logic [ADDR_W-1:0] ADDR_LOAD_CTRL = {2'h0, IDX_LOAD_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_WDT_CTRL  = {2'h0, IDX_WDT_CTRL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CAUSE     = {2'h0, IDX_CAUSE, 2'h0};

  localparam int LC_HEAVY_BIT = 0;
  localparam int LC_DUTY_BIT  = 1;
  localparam int LC_LIT_BIT   = 2;
  localparam int LC_BLANK_BIT = 3;
  localparam logic [3:0] LOAD_CTRL_RESET = 4'h8;
  localparam int WDT_RESTART_BIT = 0;

  localparam int CAUSE_POR    = 0;
  localparam int CAUSE_PIN    = 1;
  localparam int CAUSE_KEY    = 2;
  localparam int CAUSE_WDT    = 3;
  localparam int CAUSE_ACTIVE = 4;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // core start values
  localparam logic [7:0] PC_STEP_INIT   = 8'h00;
  localparam logic [3:0] PC_PAGE_INIT   = 4'h1;
  localparam logic [3:0] NEXT_PAGE_INIT = 4'h1;
  localparam logic       BANK_INIT      = 1'h0;
  localparam logic       FLAG_INIT      = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {KEY_OFF, KEY_01, KEY_012, KEY_0123} key_sel_t;
  typedef enum logic [1:0] {ST_HOLD, ST_RELEASE, ST_RUN} seq_state_t;

endpackage

// ===== rtl/hold_qualifier.sv
// level qualifier: output rises once the input has stayed high for CYCLES clocks
// assumes level is already synchronous to aclk
`timescale 1ns/1ps
module hold_qualifier
  import reset_pkg::*;
#(
  parameter int CYCLES = 2
) (
  input  wire logic aclk,    // clock
  input  wire logic aresetn, // sync reset
  input  wire logic level,   // qualified input
  output logic      hit      // held long enough
);

  localparam logic [31:0] LAST = 32'(CYCLES - 1);

  typedef struct packed {
    logic [31:0] cnt;
    logic        hit;
  } qual_t;

  qual_t r;
  qual_t n;

  always_comb begin
    n = r;
    if (!level) begin
      n.cnt = '0;
    end else if (r.cnt != LAST) begin
      n.cnt = r.cnt + 32'h1;
    end
    n.hit = level && (r.cnt == LAST);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign hit = r.hit;

endmodule // hold_qualifier

// ===== testbench/init_reset_checker.sv
// assertions on the ports of init_reset_ctrl
// assumes one aclk domain and the bind at the foot
`timescale 1ns/1ps
module init_reset_checker
  import reset_pkg::*;
#(
  parameter int PIN_HOLD = 8,
  parameter int KEY_HOLD = 16
) (
  input wire logic              aclk,             // clock
  input wire logic              aresetn,          // reset
  input wire logic [ADDR_W-1:0] araddr,           // bus
  input wire logic              arvalid,          // bus
  input wire logic              arready,          // bus
  input wire logic [31:0]       rdata,            // bus
  input wire logic [1:0]        rresp,            // bus
  input wire logic              rvalid,           // bus
  input wire logic              rready,           // bus
  input wire logic [1:0]        bresp,            // bus
  input wire logic              bvalid,           // bus
  input wire logic              bready,           // bus
  input wire logic              slow_osc_running, // osc up
  input wire logic              ext_reset_pin,    // pin
  input wire logic [3:0]        key_inputs,       // keys
  input wire logic              init_reset,       // reset out
  input wire logic [7:0]        pc_step,          // core
  input wire logic [3:0]        pc_page,          // core
  input wire logic              pc_bank,          // core
  input wire logic [3:0]        next_page_ptr,    // core
  input wire logic              next_bank_ptr,    // core
  input wire logic              int_flag,         // core
  input wire logic              dec_flag,         // core
  input wire logic              heavy_load_sel,   // ctrl
  input wire logic              all_dots_blank,   // ctrl
  input wire logic              all_dots_lit,     // ctrl
  input wire logic              drive_duty_sel    // ctrl
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  int pin_cnt;
  int key_cnt;
  // run lengths of an asserted pin and of all keys low
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_cnt <= 0;
      key_cnt <= 0;
    end else begin
      pin_cnt <= ext_reset_pin ? pin_cnt + 1 : 0;
      key_cnt <= (key_inputs == 4'h0) ? key_cnt + 1 : 0;
    end
  end
  a_core_start: assert property (init_reset |=> pc_step == PC_STEP_INIT && pc_page == PC_PAGE_INIT
    && next_page_ptr == NEXT_PAGE_INIT && !pc_bank && !next_bank_ptr) else $error("core start wrong");
  a_flag_clear: assert property (init_reset |=> !int_flag && !dec_flag) else $error("flags not clear");
  a_heavy_clear: assert property (init_reset |=> !heavy_load_sel) else $error("heavy bit kept");
  a_upper_reset: assert property (init_reset |=> all_dots_blank && !all_dots_lit
    && !drive_duty_sel) else $error("upper bits wrong");
  a_osc_wait: assert property ((!slow_osc_running)[*4] |-> init_reset) else $error("released early");
  a_pin_reset: assert property (pin_cnt == PIN_HOLD + 6 |-> init_reset) else $error("pin missed");
  a_key_reset: assert property (key_cnt == KEY_HOLD + 6 |-> init_reset) else $error("keys missed");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  a_read_unmapped: assert property (arvalid && arready && araddr == 16'h0100 |=> rvalid
    && rresp == RESP_SLVERR && rdata == 32'h0) else $error("unmapped read wrong");
endmodule // init_reset_checker

bind init_reset_ctrl init_reset_checker #(.PIN_HOLD(PIN_HOLD), .KEY_HOLD(KEY_HOLD)) init_reset_checker_i (
  .aclk             (aclk),
  .aresetn          (aresetn),
  .araddr           (araddr),
  .arvalid          (arvalid),
  .arready          (arready),
  .rdata            (rdata),
  .rresp            (rresp),
  .rvalid           (rvalid),
  .rready           (rready),
  .bresp            (bresp),
  .bvalid           (bvalid),
  .bready           (bready),
  .slow_osc_running (slow_osc_running),
  .ext_reset_pin    (ext_reset_pin),
  .key_inputs       (key_inputs),
  .init_reset       (init_reset),
  .pc_step          (pc_step),
  .pc_page          (pc_page),
  .pc_bank          (pc_bank),
  .next_page_ptr    (next_page_ptr),
  .next_bank_ptr    (next_bank_ptr),
  .int_flag         (int_flag),
  .dec_flag         (dec_flag),
  .heavy_load_sel   (heavy_load_sel),
  .all_dots_blank   (all_dots_blank),
  .all_dots_lit     (all_dots_lit),
  .drive_duty_sel   (drive_duty_sel)
);

// ===== testbench/reset_source_model.sv
// far side: oscillator, power-on, reset pin, keys and 1 Hz tick
// assumes the bench gives levels and tick requests on aclk
`timescale 1ns/1ps
module reset_source_model #(
  parameter int START = 20,
  parameter int HALF  = 4
) (
  input  wire logic       aclk,             // clock
  input  wire logic       pin_cmd,          // hold pin
  input  wire logic [3:0] key_cmd,          // key levels
  input  wire logic       tick_cmd,         // tick request
  output logic            slow_osc,         // slow clock
  output logic            slow_osc_running, // osc up
  output logic            ext_reset_pin,    // pin
  output logic [3:0]      key_inputs,       // keys
  output logic            wdt_tick          // 1 Hz pulse
);
  int cnt = 0;
  initial begin
    slow_osc = 1'b0;
    slow_osc_running = 1'b0;
    ext_reset_pin = 1'b0;
    key_inputs = 4'hf;
    wdt_tick = 1'b0;
  end
  always @(posedge aclk) begin
    cnt <= cnt + 1;
    slow_osc_running <= cnt >= START;
    // slow clock stands still until the oscillator starts
    if (slow_osc_running && cnt % HALF == 0) slow_osc <= !slow_osc;
    ext_reset_pin <= pin_cmd;
    key_inputs <= key_cmd;
    wdt_tick <= tick_cmd;
  end
endmodule // reset_source_model

// ===== testbench/tb_top.sv
// self-checking bench for init_reset_ctrl
// assumes reset_pkg, the checker bind and the source model
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module tb_top;
  import reset_pkg::*;
  localparam int PH = 8;
  localparam int KH = 16;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d, v;
  logic [3:0] wstrb, key_inputs, key_cmd, pc_page, next_page_ptr;
  logic [1:0] bresp, rresp, r;
  logic slow_osc, slow_osc_running, ext_reset_pin, wdt_tick, pin_cmd, tick_cmd, init_reset, pc_bank;
  logic next_bank_ptr, int_flag, dec_flag, heavy_load_sel, all_dots_blank, all_dots_lit, drive_duty_sel;
  logic [7:0] pc_step;
  int error_cnt = 0;
  int comparisons = 0;
  int cyc = 0;
  init_reset_ctrl #(.PIN_HOLD(PH), .KEY_HOLD(KH)) init_reset_ctrl_i (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .slow_osc(slow_osc), .slow_osc_running(slow_osc_running), .ext_reset_pin(ext_reset_pin),
    .key_inputs(key_inputs), .wdt_tick(wdt_tick), .init_reset(init_reset), .pc_step(pc_step),
    .pc_page(pc_page), .pc_bank(pc_bank), .next_page_ptr(next_page_ptr), .next_bank_ptr(next_bank_ptr),
    .int_flag(int_flag), .dec_flag(dec_flag), .heavy_load_sel(heavy_load_sel),
    .all_dots_blank(all_dots_blank), .all_dots_lit(all_dots_lit), .drive_duty_sel(drive_duty_sel));
  reset_source_model reset_source_model_i (.aclk(aclk), .pin_cmd(pin_cmd), .key_cmd(key_cmd),
    .tick_cmd(tick_cmd), .slow_osc(slow_osc), .slow_osc_running(slow_osc_running),
    .ext_reset_pin(ext_reset_pin), .key_inputs(key_inputs), .wdt_tick(wdt_tick));
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] exp_ctrl(input logic [31:0] x);
    return {28'h0, x[3:0]};
  endfunction
  task automatic finish_test;
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] x);
    bit ad;
    bit dd;
    ad = 0;
    dd = 0;
    awaddr <= a; wdata <= x; wstrb <= 4'hf; awvalid <= 1; wvalid <= 1; bready <= 1;
    do begin
      @(posedge aclk);
      if (awready) ad = 1;
      if (wready) dd = 1;
      awvalid <= !ad;
      wvalid <= !dd;
    end while (!(ad && dd));
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [ADDR_W-1:0] a);
    araddr <= a; arvalid <= 1; rready <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge aclk);
  endtask
  task automatic wait_ir(input logic x);
    int i;
    i = 0;
    while (init_reset !== x && i < 400) begin @(posedge aclk); i++; end
    `CHK("init_reset", x, init_reset)
  endtask
  task automatic hold(input int n, input logic p, input logic [3:0] k);
    pin_cmd <= p; key_cmd <= k;
    repeat (n) @(posedge aclk);
    pin_cmd <= 0; key_cmd <= 4'hf;
    repeat (8) @(posedge aclk);
  endtask
  task automatic ticks(input int n);
    repeat (n) begin tick_cmd <= 1; @(posedge aclk); tick_cmd <= 0; repeat (5) @(posedge aclk); end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    aclk = 0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin error_cnt++; finish_test; end
  end
  initial begin
    void'($urandom(32'h80ee));
    aresetn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0; awaddr = '0; araddr = '0;
    wdata = '0; wstrb = '0; pin_cmd = 0; key_cmd = 4'hf; tick_cmd = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    repeat (6) @(posedge aclk);
    `CHK("osc wait", 1'b1, init_reset)
    wait_ir(0);
    `CHK("core", {8'h00, 4'h1, 4'h1, 4'h0}, {pc_step, pc_page, next_page_ptr, pc_bank, next_bank_ptr, int_flag, dec_flag})
    axi_rd(ADDR_LOAD_CTRL);
    `CHK("ctrl reset", 32'h8, d)
    repeat (8) begin
      v = $urandom;
      axi_wr(ADDR_LOAD_CTRL, v);
      `CHK("bresp", RESP_OKAY, r)
      axi_rd(ADDR_LOAD_CTRL);
      `CHK("rresp", RESP_OKAY, r)
      `CHK("ctrl", exp_ctrl(v), d)
      `CHK("heavy", v[0], heavy_load_sel)
      `CHK("ctrl pins", v[3:0], {all_dots_blank, all_dots_lit, drive_duty_sel, heavy_load_sel})
    end
    axi_rd(16'h0100);
    `CHK("unmapped", RESP_SLVERR, r)
    axi_wr(ADDR_LOAD_CTRL, 32'h1);
    repeat (PH) @(posedge aclk);
    `CHK("heavy set", 1'b1, heavy_load_sel)
    repeat (KH) @(posedge aclk);
    axi_wr(ADDR_LOAD_CTRL, 32'h0);
    `CHK("heavy left", 1'b0, heavy_load_sel)
    axi_wr(ADDR_LOAD_CTRL, 32'h1);
    hold(PH - 3, 1, 4'hf);
    `CHK("short pin", 1'b0, init_reset)
    axi_rd(ADDR_CAUSE);
    `CHK("no pin cause", 1'b0, d[CAUSE_PIN])
    hold(PH + 8, 1, 4'hf);
    wait_ir(0);
    `CHK("heavy cleared", 1'b0, heavy_load_sel)
    axi_rd(ADDR_CAUSE);
    `CHK("pin cause", 1'b1, d[CAUSE_PIN])
    hold(KH + 8, 0, 4'h8);
    `CHK("partial keys", 1'b0, init_reset)
    hold(KH - 4, 0, 4'h0);
    `CHK("short keys", 1'b0, init_reset)
    axi_rd(ADDR_CAUSE);
    `CHK("no key cause", 1'b0, d[CAUSE_KEY])
    hold(KH + 8, 0, 4'h0);
    wait_ir(0);
    axi_rd(ADDR_CAUSE);
    `CHK("key cause", 1'b1, d[CAUSE_KEY])
    ticks(3);
    axi_wr(ADDR_WDT_CTRL, 32'h1);
    ticks(3);
    `CHK("restarted", 1'b0, init_reset)
    axi_rd(ADDR_CAUSE);
    `CHK("no wdt cause", 1'b0, d[CAUSE_WDT])
    // single tick, then watch at once: the slow edge may end the reset a few cycles later
    tick_cmd <= 1;
    @(posedge aclk);
    tick_cmd <= 0;
    wait_ir(1);
    wait_ir(0);
    axi_rd(ADDR_CAUSE);
    `CHK("wdt cause", 1'b1, d[CAUSE_WDT])
    axi_wr(ADDR_CAUSE, 32'h1f);
    axi_rd(ADDR_CAUSE);
    `CHK("causes cleared", 32'h0, d)
    finish_test;
  end
endmodule // tb_top
